// file: rtl/cjb_defines.svh
// constants for the jitter buffer and c1/c2 correction block
`ifndef CJB_DEFINES_SVH
`define CJB_DEFINES_SVH
`define CJB_SYM_W        8          // symbol width
`define CJB_RAM_AW       11         // 2k-word buffer address
`define CJB_FRM_AW       6          // frame pointer width (64 frames)
`define CJB_SYM_AW       5          // symbol index in a frame
`define CJB_LAST_SYM     5'h1f      // last symbol of a frame
`define CJB_CW_LEN       28         // symbols per c2 codeword
`define CJB_CW_LAST      5'h1b      // last c2 codeword symbol index
`define CJB_CENTER       6'h20      // nominal write-read distance
`define CJB_POS_MAX      6'sh04     // overflow at +4 or more
`define CJB_POS_MIN      6'sh3c     // overflow at -4 or less
`define CJB_DIV_W        10         // playback divisor width
`define CJB_DIV_SLOW     10'h24d    // 589, behind the centre
`define CJB_DIV_STD      10'h24c    // 588, centred
`define CJB_DIV_FAST     10'h24b    // 587, ahead of the centre
`define CJB_MUTE_FRAMES  8'h80      // 128 frames of mute
`define CJB_ERR_NONE     2'h0       // error count codes
`define CJB_ERR_ONE      2'h1
`define CJB_ERR_TWO      2'h2
`define CJB_ERR_MANY     2'h3
`define CJB_C2_SKIP_MIN  5'h07      // two matches: skip at 7 or more flags
`define CJB_C2_HALF_MAX  5'h05      // one match: set all at 5 or fewer
`define CJB_C2_NONE_MAX  5'h02      // no match / many: set all at 2 or fewer
`endif

// file: rtl/cjb_pkg.sv
// types shared by the jitter buffer and correction block
package cjb_pkg;
   // correction and readout sequence
   typedef enum logic [2:0] {
      ST_IDLE, ST_C1_WAIT, ST_C1_FIX, ST_C2_WAIT, ST_C2_FIX, ST_OUT
   } cjb_state_t;
endpackage : cjb_pkg

// file: rtl/cjb_skid_buf.sv
// two-entry buffer between readout and the downstream interpolator
`timescale 1ns/10ps
`include "cjb_defines.svh"
module cjb_skid_buf #(
   parameter int W = 9                            // word width
) (
   input  wire logic         sys_clk_i,           // system clock
   input  wire logic         rst_b_i,             // sync reset, low
   input  wire logic         in_valid_i,          // word offered
   input  wire logic [W-1:0] in_data_i,           // offered word
   output logic              in_ready_o,          // room for a word
   output logic              out_valid_o,         // word held at output
   output logic [W-1:0]      out_data_o,          // output word
   input  wire logic         out_ready_i          // receiver takes word
);
   logic         skid_valid_ff;                   // second entry full
   logic [W-1:0] skid_data_ff;                    // second entry
   logic         nxt_out_valid, nxt_skid_valid;   // next fill state
   logic [W-1:0] nxt_out_data, nxt_skid_data;     // next contents

   ////////////////////////////////////////////////////////////////////
   // ready depends only on a flop, so no combinational path upstream
   always_comb begin
      nxt_out_valid  = out_valid_o;
      nxt_out_data   = out_data_o;
      nxt_skid_valid = skid_valid_ff;
      nxt_skid_data  = skid_data_ff;
      if (out_ready_i || !out_valid_o) begin
         // front entry frees: refill from skid first to keep order
         if (skid_valid_ff) begin
            nxt_out_data   = skid_data_ff;
            nxt_out_valid  = 1'b1;
            nxt_skid_valid = 1'b0;
         end else if (in_valid_i) begin
            nxt_out_data  = in_data_i;
            nxt_out_valid = 1'b1;
         end else begin
            nxt_out_valid = 1'b0;
         end
      end else if (in_valid_i && !skid_valid_ff) begin
         // receiver stalled: park the word rather than drop it
         nxt_skid_data  = in_data_i;
         nxt_skid_valid = 1'b1;
      end
   end

   // register stage
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         out_valid_o   <= 1'b0;
         out_data_o    <= '0;
         skid_valid_ff <= 1'b0;
         skid_data_ff  <= '0;
      end else begin
         out_valid_o   <= nxt_out_valid;
         out_data_o    <= nxt_out_data;
         skid_valid_ff <= nxt_skid_valid;
         skid_data_ff  <= nxt_skid_data;
      end
   end

   assign in_ready_o = !skid_valid_ff;
endmodule : cjb_skid_buf

// file: rtl/cjb_c2_flag_dec.sv
// c2 flag decision from c2 error count and the c1 flags
`timescale 1ns/10ps
`include "cjb_defines.svh"
module cjb_c2_flag_dec (
   input  wire logic [1:0]             err_cnt_i,  // c2 error count code
   input  wire logic [`CJB_CW_LEN-1:0] c1_flags_i, // c1 flags per symbol
   input  wire logic [4:0]             pos0_i,     // first error position
   input  wire logic [4:0]             pos1_i,     // second error position
   output logic                        fix_o,      // apply c2 correction
   output logic [`CJB_CW_LEN-1:0]      flags_o,    // resulting c2 flags
   output logic [4:0]                  c1_cnt_o    // number of c1 flags
);
   logic match0, match1;                           // position hits a c1 flag

   ////////////////////////////////////////////////////////////////////
   // count c1 flags and compare error positions against them
   always_comb begin
      c1_cnt_o = 5'h00;
      for (int i = 0; i < `CJB_CW_LEN; i++) begin
         c1_cnt_o = c1_cnt_o + 5'(c1_flags_i[i]);
      end
      match0 = (pos0_i <= `CJB_CW_LAST) && c1_flags_i[pos0_i];
      match1 = (pos1_i <= `CJB_CW_LAST) && c1_flags_i[pos1_i];
   end

   // decision table
   always_comb begin
      fix_o   = 1'b0;
      flags_o = c1_flags_i;
      unique case (err_cnt_i)
         `CJB_ERR_NONE: flags_o = '0;
         `CJB_ERR_ONE: begin
            fix_o   = 1'b1;
            flags_o = '0;
         end
         `CJB_ERR_TWO: begin
            if (c1_cnt_o >= `CJB_C2_SKIP_MIN) begin
               flags_o = c1_flags_i;
            end else if (match0 && match1) begin
               fix_o   = 1'b1;
               flags_o = '0;
            end else if (match0 || match1) begin
               // c1 looks unreliable with few flags: distrust all
               flags_o = (c1_cnt_o <= `CJB_C2_HALF_MAX) ? '1 : c1_flags_i;
            end else begin
               flags_o = (c1_cnt_o <= `CJB_C2_NONE_MAX) ? '1 : c1_flags_i;
            end
         end
         `CJB_ERR_MANY: flags_o = (c1_cnt_o <= `CJB_C2_NONE_MAX) ? '1 : c1_flags_i;
      endcase
   end
endmodule : cjb_c2_flag_dec

// file: rtl/cjb_top.sv
// jitter buffer with playback divider steering and c1/c2 correction
`timescale 1ns/10ps
`include "cjb_defines.svh"
// Summary of operation
// - byte buffer of 2k words absorbs jitter
// - steer write position to centre via divider
// - divisor 589 behind, 588 centred, 587 ahead
// - at plus/minus four, force write to centre
// - mute 128 frames after forced re-centre
// - crystal timed: c1 and flags, then c2
// - c1 flag set from two errors upward
// - c2 zero or one error: clear flags
// - two matched errors fix; seven flags copy
// - one match: set if five or fewer flags
// - no match: set if two or fewer flags
// - three c2 errors: set if few, else copy
module cjb_top
   import cjb_pkg::*;
(
   input  wire logic                  sys_clk_i,         // 200 MHz system clock
   input  wire logic                  rst_b_i,           // sync reset, low
   input  wire logic                  sym_valid_i,       // demodulated symbol strobe
   input  wire logic [`CJB_SYM_W-1:0] sym_data_i,        // demodulated symbol
   input  wire logic                  xtal_frame_i,      // crystal frame enable pulse
   input  wire logic                  c1_res_valid_i,    // c1 check result ready
   input  wire logic [1:0]            c1_err_cnt_i,      // c1 error count code
   input  wire logic [4:0]            c1_pos0_i,         // c1 first error symbol
   input  wire logic [`CJB_SYM_W-1:0] c1_mag0_i,         // c1 first error value
   input  wire logic [4:0]            c1_pos1_i,         // c1 second error symbol
   input  wire logic [`CJB_SYM_W-1:0] c1_mag1_i,         // c1 second error value
   input  wire logic                  c2_res_valid_i,    // c2 check result ready
   input  wire logic [1:0]            c2_err_cnt_i,      // c2 error count code
   input  wire logic [4:0]            c2_pos0_i,         // c2 first error symbol
   input  wire logic [`CJB_SYM_W-1:0] c2_mag0_i,         // c2 first error value
   input  wire logic [4:0]            c2_pos1_i,         // c2 second error symbol
   input  wire logic [`CJB_SYM_W-1:0] c2_mag1_i,         // c2 second error value
   output logic                       chk_req_o,         // start a check, pulse
   output logic                       chk_stage_o,       // 0 c1, 1 c2
   output logic [`CJB_FRM_AW-1:0]     chk_frame_o,       // frame under check
   output logic                       out_valid_o,       // output symbol valid
   output logic [`CJB_SYM_W-1:0]      out_data_o,        // output symbol
   output logic                       out_flag_o,        // c2 flag or mute
   input  wire logic                  out_ready_i,       // downstream takes symbol
   output logic                       mute_o,            // timed mute active
   output logic                       recentre_o,        // forced re-centre pulse
   output logic                       playback_bit_clock_o, // divided enable pulse
   output logic [`CJB_DIV_W-1:0]      pbk_divisor_o,     // divisor in use
   output logic [`CJB_FRM_AW-1:0]     buf_pos_o          // signed buffer position
);
   ////////////////////////////////////////////////////////////////////
   // buffer memory and pointers
   logic [`CJB_SYM_W-1:0]  ram_mem [0:(1<<`CJB_RAM_AW)-1]; // symbol buffer
   logic [`CJB_FRM_AW-1:0] wr_frm_ff, nxt_wr_frm;          // write frame
   logic [`CJB_SYM_AW-1:0] wr_sym_ff, nxt_wr_sym;          // write symbol
   logic [`CJB_FRM_AW-1:0] rd_frm_ff, nxt_rd_frm;          // crystal read frame
   logic [7:0]             mute_cnt_ff, nxt_mute_cnt;      // frames left muted
   logic                   nxt_mute, nxt_recentre;         // next outputs
   logic [`CJB_FRM_AW-1:0] pos_now;                        // live position
   logic [`CJB_DIV_W-1:0]  div_cnt_ff, nxt_div_cnt;        // divider count
   logic [`CJB_DIV_W-1:0]  nxt_div;                        // chosen divisor
   logic                   nxt_pbk;                        // divider pulse

   // pointer, overflow and divider steering
   always_comb begin
      nxt_wr_frm   = wr_frm_ff;
      nxt_wr_sym   = wr_sym_ff;
      nxt_rd_frm   = rd_frm_ff;
      nxt_mute_cnt = mute_cnt_ff;
      nxt_recentre = 1'b0;
      pos_now      = wr_frm_ff - rd_frm_ff - `CJB_CENTER;
      if (sym_valid_i) begin
         nxt_wr_sym = wr_sym_ff + 5'h01;
         if (wr_sym_ff == `CJB_LAST_SYM) nxt_wr_frm = wr_frm_ff + 6'h01;
      end
      if (xtal_frame_i) begin
         nxt_rd_frm = rd_frm_ff + 6'h01;
         if (mute_cnt_ff != 8'h00) nxt_mute_cnt = mute_cnt_ff - 8'h01;
      end
      // window exhausted: jump back to centre, errors cannot be flagged
      if ($signed(pos_now) >= `CJB_POS_MAX || $signed(pos_now) <= `CJB_POS_MIN) begin
         nxt_wr_frm   = nxt_rd_frm + `CJB_CENTER;
         nxt_wr_sym   = 5'h00;
         nxt_mute_cnt = `CJB_MUTE_FRAMES;
         nxt_recentre = 1'b1;
      end
      nxt_mute = (nxt_mute_cnt != 8'h00);
      // behind centre slows the playback side, ahead speeds it
      if ($signed(pos_now) < 0) nxt_div = `CJB_DIV_SLOW;
      else if (pos_now == 6'h00) nxt_div = `CJB_DIV_STD;
      else nxt_div = `CJB_DIV_FAST;
      if (div_cnt_ff == 10'h000) begin
         nxt_pbk     = 1'b1;
         nxt_div_cnt = nxt_div - 10'h001;
      end else begin
         nxt_pbk     = 1'b0;
         nxt_div_cnt = div_cnt_ff - 10'h001;
      end
   end

   // pointer registers
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         wr_frm_ff            <= `CJB_CENTER;
         wr_sym_ff            <= 5'h00;
         rd_frm_ff            <= 6'h00;
         mute_cnt_ff          <= 8'h00;
         mute_o               <= 1'b0;
         recentre_o           <= 1'b0;
         div_cnt_ff           <= 10'h000;
         playback_bit_clock_o <= 1'b0;
         pbk_divisor_o        <= `CJB_DIV_STD;
         buf_pos_o            <= 6'h00;
      end else begin
         wr_frm_ff            <= nxt_wr_frm;
         wr_sym_ff            <= nxt_wr_sym;
         rd_frm_ff            <= nxt_rd_frm;
         mute_cnt_ff          <= nxt_mute_cnt;
         mute_o               <= nxt_mute;
         recentre_o           <= nxt_recentre;
         div_cnt_ff           <= nxt_div_cnt;
         playback_bit_clock_o <= nxt_pbk;
         pbk_divisor_o        <= nxt_div;
         buf_pos_o            <= pos_now;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // correction sequencer and readout
   cjb_state_t              state_ff, nxt_state;          // sequence state
   logic [`CJB_FRM_AW-1:0]  proc_frm_ff, nxt_proc_frm;    // frame in work
   logic [1:0]              fix_n_ff, nxt_fix_n;          // fixes to apply
   logic                    fix_idx_ff, nxt_fix_idx;      // fix in progress
   logic [4:0]              pos0_ff, pos1_ff, nxt_pos0, nxt_pos1; // fix places
   logic [`CJB_SYM_W-1:0]   mag0_ff, mag1_ff, nxt_mag0, nxt_mag1; // fix values
   logic [`CJB_CW_LEN-1:0]  c1_flags_ff, nxt_c1_flags;    // c1 flag register
   logic [`CJB_CW_LEN-1:0]  c2_flags_ff, nxt_c2_flags;    // c2 flags for readout
   logic [`CJB_SYM_AW-1:0]  idx_ff, nxt_idx;              // readout symbol
   logic                    nxt_req, nxt_stage;           // check request
   logic                    ram_we;                       // buffer write
   logic [`CJB_RAM_AW-1:0]  ram_wa, ram_ra;               // buffer addresses
   logic [`CJB_SYM_W-1:0]   ram_wd, ram_rd;               // buffer data
   logic                    dec_fix;                      // c2 decision: fix
   logic [`CJB_CW_LEN-1:0]  dec_flags;                    // c2 decision: flags
   logic [4:0]              c1_cnt;                       // c1 flag count
   logic                    sb_valid, sb_ready;           // into output buffer
   logic [`CJB_SYM_W:0]     sb_data;                      // flag and symbol

   // number of symbol fixes an error count code asks for
   function automatic logic [1:0] fixes(input logic [1:0] err);
      fixes = (err == `CJB_ERR_ONE) ? 2'h1 : (err == `CJB_ERR_TWO) ? 2'h2 : 2'h0;
   endfunction : fixes

   cjb_c2_flag_dec u_c2_dec (
      .err_cnt_i  (c2_err_cnt_i),
      .c1_flags_i (c1_flags_ff),
      .pos0_i     (c2_pos0_i),
      .pos1_i     (c2_pos1_i),
      .fix_o      (dec_fix),
      .flags_o    (dec_flags),
      .c1_cnt_o   (c1_cnt)
   );

   // next sequence state; the demodulator always wins the write port
   always_comb begin
      nxt_state    = state_ff;
      nxt_proc_frm = proc_frm_ff;
      nxt_fix_n    = fix_n_ff;
      nxt_fix_idx  = fix_idx_ff;
      nxt_pos0     = pos0_ff;
      nxt_pos1     = pos1_ff;
      nxt_mag0     = mag0_ff;
      nxt_mag1     = mag1_ff;
      nxt_c1_flags = c1_flags_ff;
      nxt_c2_flags = c2_flags_ff;
      nxt_idx      = idx_ff;
      nxt_req      = 1'b0;
      nxt_stage    = chk_stage_o;
      sb_valid     = 1'b0;
      ram_ra       = {proc_frm_ff, fix_idx_ff ? pos1_ff : pos0_ff};
      ram_we       = sym_valid_i;
      ram_wa       = {wr_frm_ff, wr_sym_ff};
      ram_wd       = sym_data_i;
      unique case (state_ff)
         ST_IDLE: if (xtal_frame_i) begin
            nxt_proc_frm = rd_frm_ff;
            nxt_req      = 1'b1;
            nxt_stage    = 1'b0;
            nxt_state    = ST_C1_WAIT;
         end
         ST_C1_WAIT: if (c1_res_valid_i) begin
            nxt_c1_flags = {c1_flags_ff[`CJB_CW_LEN-2:0], c1_err_cnt_i >= `CJB_ERR_TWO};
            nxt_fix_n    = fixes(c1_err_cnt_i);
            nxt_fix_idx  = 1'b0;
            {nxt_pos0, nxt_mag0, nxt_pos1, nxt_mag1} = {c1_pos0_i, c1_mag0_i, c1_pos1_i, c1_mag1_i};
            nxt_state    = ST_C1_FIX;
         end
         ST_C2_WAIT: if (c2_res_valid_i) begin
            nxt_c2_flags = dec_flags;
            nxt_fix_n    = dec_fix ? fixes(c2_err_cnt_i) : 2'h0;
            nxt_fix_idx  = 1'b0;
            {nxt_pos0, nxt_mag0, nxt_pos1, nxt_mag1} = {c2_pos0_i, c2_mag0_i, c2_pos1_i, c2_mag1_i};
            nxt_state    = ST_C2_FIX;
         end
         ST_C1_FIX, ST_C2_FIX: begin
            if ({1'b0, fix_idx_ff} < fix_n_ff) begin
               // read-modify-write, held off while a symbol arrives
               if (!sym_valid_i) begin
                  ram_we      = 1'b1;
                  ram_wa      = ram_ra;
                  ram_wd      = ram_rd ^ (fix_idx_ff ? mag1_ff : mag0_ff);
                  nxt_fix_idx = 1'b1;
                  if (fix_idx_ff) nxt_fix_n = 2'h0;
               end
            end else if (state_ff == ST_C1_FIX) begin
               nxt_req   = 1'b1;
               nxt_stage = 1'b1;
               nxt_state = ST_C2_WAIT;
            end else begin
               nxt_idx   = 5'h00;
               nxt_state = ST_OUT;
            end
         end
         ST_OUT: begin
            ram_ra   = {proc_frm_ff, idx_ff};
            sb_valid = 1'b1;
            if (sb_ready) begin
               nxt_idx = idx_ff + 5'h01;
               if (idx_ff == `CJB_LAST_SYM) nxt_state = ST_IDLE;
            end
         end
      endcase
      ram_rd  = ram_mem[ram_ra];
      sb_data = {mute_o || (idx_ff <= `CJB_CW_LAST && c2_flags_ff[idx_ff]), ram_rd};
   end

   // sequence registers
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         state_ff    <= ST_IDLE;
         proc_frm_ff <= 6'h00;
         fix_n_ff    <= 2'h0;
         fix_idx_ff  <= 1'b0;
         pos0_ff     <= 5'h00;
         pos1_ff     <= 5'h00;
         mag0_ff     <= 8'h00;
         mag1_ff     <= 8'h00;
         c1_flags_ff <= '0;
         c2_flags_ff <= '0;
         idx_ff      <= 5'h00;
         chk_req_o   <= 1'b0;
         chk_stage_o <= 1'b0;
         chk_frame_o <= 6'h00;
      end else begin
         state_ff    <= nxt_state;
         proc_frm_ff <= nxt_proc_frm;
         fix_n_ff    <= nxt_fix_n;
         fix_idx_ff  <= nxt_fix_idx;
         pos0_ff     <= nxt_pos0;
         pos1_ff     <= nxt_pos1;
         mag0_ff     <= nxt_mag0;
         mag1_ff     <= nxt_mag1;
         c1_flags_ff <= nxt_c1_flags;
         c2_flags_ff <= nxt_c2_flags;
         idx_ff      <= nxt_idx;
         chk_req_o   <= nxt_req;
         chk_stage_o <= nxt_stage;
         chk_frame_o <= nxt_proc_frm;
      end
   end

   // buffer memory write port, no reset on storage
   always_ff @(posedge sys_clk_i) begin
      if (ram_we) ram_mem[ram_wa] <= ram_wd;
   end

   cjb_skid_buf #(.W(`CJB_SYM_W + 1)) u_out_buf (
      .sys_clk_i   (sys_clk_i),
      .rst_b_i     (rst_b_i),
      .in_valid_i  (sb_valid),
      .in_data_i   (sb_data),
      .in_ready_o  (sb_ready),
      .out_valid_o (out_valid_o),
      .out_data_o  ({out_flag_o, out_data_o}),
      .out_ready_i (out_ready_i)
   );

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_c1_done;
      state_ff == ST_C1_FIX ##1 state_ff == ST_C2_WAIT;
   endsequence
   sequence s_c2_hit(logic [1:0] e);
      state_ff == ST_C2_WAIT && c2_res_valid_i && c2_err_cnt_i == e;
   endsequence

   AST_POS_BOUND: assert property ($signed(buf_pos_o) <= 4 && $signed(buf_pos_o) >= -4)
      else $error("buffer position left the window");
   AST_DIV_PERIOD: assert property (playback_bit_clock_o |=> !playback_bit_clock_o [*8])
      else $error("playback divider pulsed too soon");
   AST_DIV_CHOICE: assert property (($signed(buf_pos_o) < 0 |-> pbk_divisor_o == 10'h24d) and
      (buf_pos_o == 6'h00 |-> pbk_divisor_o == 10'h24c) and ($signed(buf_pos_o) > 0 |-> pbk_divisor_o == 10'h24b))
      else $error("divisor does not follow position");
   AST_RECENTRE_POS: assert property (recentre_o |-> pos_now == 6'h00 && wr_sym_ff == 5'h00)
      else $error("re-centre did not land on centre");
   AST_RECENTRE_MUTE: assert property (recentre_o |-> mute_o && mute_cnt_ff == 8'h80 ##1 mute_o)
      else $error("re-centre without 128-frame mute");
   AST_C1_THEN_C2: assert property (s_c1_done |-> chk_req_o && chk_stage_o)
      else $error("c2 check started without c1 order");
   AST_C1_FLAG: assert property (state_ff == ST_C1_WAIT && c1_res_valid_i |=>
      c1_flags_ff[0] == ($past(c1_err_cnt_i) >= 2'h2) && fix_n_ff == ($past(c1_err_cnt_i) == 2'h3 ? 2'h0 :
      $past(c1_err_cnt_i)))
      else $error("c1 flag or fix count wrong");
   AST_C2_CLEAN: assert property (s_c2_hit(2'h1) |=> c2_flags_ff == '0 && fix_n_ff == 2'h1)
      else $error("single c2 error not fixed and cleared");
   AST_C2_SKIP: assert property (s_c2_hit(2'h2) && c1_cnt >= 5'h07 |=>
      fix_n_ff == 2'h0 && c2_flags_ff == $past(c1_flags_ff))
      else $error("c2 did not copy c1 flags at seven");
   AST_C2_MANY: assert property (s_c2_hit(2'h3) && c1_cnt <= 5'h02 |=> c2_flags_ff == '1 && fix_n_ff == 2'h0)
      else $error("c2 many errors with few flags not set");
endmodule : cjb_top

// file: tb/cjb_far_model.sv
// far side: c1/c2 checker answers and a stalling sink
`timescale 1ns/10ps
module cjb_far_model (
   input  wire logic sys_clk_i,   // clock
   input  wire logic chk_req_i,   // check start pulse
   input  wire logic chk_stage_i, // 0 c1, 1 c2
   output logic      c1_vld_o,    // c1 result pulse
   output logic      c2_vld_o,    // c2 result pulse
   output logic      rdy_o,       // sink ready
   output logic [4:0] p0_o,       // first error symbol
   output logic [4:0] p1_o,       // second, never a flag slot
   output logic [7:0] m0_o,       // first error value
   output logic [7:0] m1_o        // second error value
);
   logic [1:0] cnt_q;             // answer delay
   logic       stg_q;             // stage asked for
   initial {c1_vld_o, c2_vld_o, rdy_o, cnt_q, stg_q, p0_o, p1_o, m0_o, m1_o} = {6'h00, 10'h03e, 16'h5aa5};
   ///////////////////////////////////////////////////////////////////
   // answer three cycles late; sink stalls every other cycle
   always @(negedge sys_clk_i) begin
      rdy_o    <= ~rdy_o;
      c1_vld_o <= (cnt_q == 2'h1) & ~stg_q;
      c2_vld_o <= (cnt_q == 2'h1) & stg_q;
      if (chk_req_i) begin
         cnt_q <= 2'h3;
         stg_q <= chk_stage_i;
      end else if (cnt_q != 2'h0) cnt_q <= cnt_q - 2'h1;
   end
endmodule : cjb_far_model

// file: tb/tb_top.sv
// bench for the jitter buffer and c1/c2 flag block
`timescale 1ns/10ps
module tb_top;
   logic       clk = 0, rst_b = 0, sv = 0, xf = 0, c1v, c2v, rdy, req, stg, ov, of, mu, pb; // controls
   logic [7:0] sd = 8'h00, od, m0, m1;  // data
   logic [4:0] p0, p1;                  // error slots
   logic [1:0] e1 = 2'h0, e2 = 2'h0;    // error counts
   logic [5:0] pos;                     // position
   logic [9:0] dv;                      // divisor
   logic       rc, rcs = 0, dk = 0;     // re-centre pulse, seen, data check on
   logic [5:0] cf;                      // frame under check
   int         n_errors = 0, checks = 0, k, s;
   initial forever #2.5 clk = ~clk;
   cjb_far_model far_u (.sys_clk_i(clk), .chk_req_i(req), .chk_stage_i(stg), .c1_vld_o(c1v), .c2_vld_o(c2v),
      .rdy_o(rdy), .p0_o(p0), .p1_o(p1), .m0_o(m0), .m1_o(m1));
   cjb_top dut_u (.sys_clk_i(clk), .rst_b_i(rst_b), .sym_valid_i(sv), .sym_data_i(sd), .xtal_frame_i(xf),
      .c1_res_valid_i(c1v), .c1_err_cnt_i(e1), .c1_pos0_i(p0), .c1_mag0_i(m0), .c1_pos1_i(p1), .c1_mag1_i(m1),
      .c2_res_valid_i(c2v), .c2_err_cnt_i(e2), .c2_pos0_i(p0), .c2_mag0_i(m0), .c2_pos1_i(p1), .c2_mag1_i(m1),
      .chk_req_o(req), .chk_stage_o(stg), .chk_frame_o(cf), .out_valid_o(ov), .out_data_o(od), .out_flag_o(of),
      .out_ready_i(rdy), .mute_o(mu), .recentre_o(rc), .playback_bit_clock_o(pb), .pbk_divisor_o(dv),
      .buf_pos_o(pos));
   // the re-centre pulse stands one cycle only, so latch it
   always @(posedge clk) if (rc === 1'b1) rcs <= 1'b1;
   ///////////////////////////////////////////////////////////////////
   // compare and verdict
   task automatic cmp(string nm, logic [9:0] got, logic [9:0] ex);
      checks++;
      if (got !== ex) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask : cmp
   task automatic summarize;
      if (n_errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize
   ///////////////////////////////////////////////////////////////////
   // stimulus helpers, all driven on the falling edge
   task automatic xt;
      @(negedge clk) xf = 1'b1;
      @(negedge clk) xf = 1'b0;
      repeat (3) @(negedge clk);
   endtask : xt
   task automatic wr_frames(int n);
      for (k = 0; k < n * 32; k++) @(negedge clk) {sv, sd} = {1'b1, k[7:0]};
      @(negedge clk) sv = 1'b0;
      repeat (3) @(negedge clk);
   endtask : wr_frames
   // one corrected frame; flags of symbols below n must be set, the rest clear
   task automatic frame(logic [1:0] a, logic [1:0] b, int n);
      int j;
      logic [7:0] x;
      {e1, e2, j} = {a, b, 32'd0};
      xt();
      for (k = 0; k < 2000 && j < 32; k++) begin
         @(negedge clk);
         #1;
         if (ov === 1'b1 && rdy === 1'b1) begin
            cmp("flag", {9'h0, of}, {9'h0, j < n});
            // model fixes: symbol 1 by c1 one/two and c2 one, symbol 30 by c1 two
            x = 8'(j) ^ ((j == 1 && ((a == 2'h1 || a == 2'h2) != (b == 2'h1))) ? 8'h5a : 8'h00);
            if (dk) cmp("data", {2'h0, od}, {2'h0, x ^ ((j == 30 && a == 2'h2) ? 8'ha5 : 8'h00)});
            j++;
         end
      end
      if (j < 32) begin
         n_errors++;
         summarize();
      end
   endtask : frame
   // pulse spacing of the divided playback enable
   task automatic period(logic [9:0] ex);
      int c;
      for (k = 0; k < 700 && pb !== 1'b1; k++) @(negedge clk);
      @(negedge clk);
      for (c = 1; c < 700 && pb !== 1'b1; c++) @(negedge clk);
      cmp("period", c[9:0], ex);
      if (k == 700 || c == 700) begin
         n_errors++;
         summarize();
      end
   endtask : period
   ///////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      cmp("div", dv, 10'h24c);
      period(10'h24c);
      frame(2'h0, 2'h0, 0);
      cmp("pos", {4'h0, pos}, 10'h03f);
      frame(2'h2, 2'h3, 28);
      cmp("frame", {4'h0, cf}, 10'h001);
      period(10'h24d);
      wr_frames(3);
      cmp("div", dv, 10'h24b);
      cmp("recentre", {9'h0, rcs}, 10'h000);
      wr_frames(3);
      cmp("recentre", {9'h0, rcs}, 10'h001);
      cmp("mute", {9'h0, mu}, 10'h001);
      cmp("pos", {4'h0, pos}, 10'h000);
      // one written frame per crystal frame keeps the position near zero
      for (s = 0; s < 128; s++) begin
         if (s == 127) cmp("mute", {9'h0, mu}, 10'h001);
         wr_frames(1);
         xt();
      end
      cmp("mute", {9'h0, mu}, 10'h000);
      // let the last readout drain; every frame now holds symbol index as data
      dk = 1'b1;
      repeat (100) @(negedge clk);
      for (s = 0; s < 28; s++) begin
         wr_frames(1);
         frame(2'h0, 2'h0, 0);
      end
      // c1 flag register is empty: single c2 error, then one match, then none
      frame(2'h2, 2'h1, 0);
      frame(2'h0, 2'h2, 28);
      frame(2'h0, 2'h2, 28);
      repeat (3) wr_frames(1);
      // fill the c1 flag register, then two c2 errors take the copy path
      for (s = 0; s < 28; s++) begin
         wr_frames(1);
         frame(2'h2, 2'h0, 0);
      end
      frame(2'h2, 2'h2, 28);
      summarize();
   end
endmodule : tb_top
